// ---- design/chained_event_counters.sv ----
// Purpose: Bank of eighteen chainable event counters with control registers
// Assumes: Events and register port are synchronous to mclk
// Notes: Register port reads return data the cycle after the strobe
// Function
// - Setting the enable bit starts counting; counting continues while set.
// - Clearing enable stops increments and keeps the reached count.
// - Reads return the live count without disturbing counting.
// - Passing the maximum wraps to zero and counting continues.
// - Every wrap sets a sticky overflow flag until software clears it.
// - A chained counter starts by itself when its partner overflows.
// - A chain-started counter stops on clearing its chain bit or source flag.
// - Counters come in pairs with own controls; nine pairs in four blocks.
// - Fourth block holds counters 12 to 17, local controls zero to five.
// - In a block, counters 0 and 2, and 1 and 3, chain both ways.
// - Every later block pairs first with third and second with fourth.
// - Counters 16 and 17 chain only from 14 and 15, never reversed.
// - Counters 16 and 17 never start another through normal chaining.
// - Bit 11 is extended chaining in block four, reserved in its controls 1, 2.
// - Local counter 4 overflow starts local 0 or 5 by their bit 11.
// - Local counter 5 overflow starts local 3 or 4 by their bit 11.
// - Extended targets are started by their bit 11, not the chain bit.
// - An enabled counter adds its 0 to 15 event value every cycle.
// - Overflow with interrupt enable raises the performance monitor request.
// - Force-wrap makes every increment an overflow with all its effects.
//
// The address-and-strobe port and the address map were left to the implementer.
`default_nettype none
module chained_event_counters (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [chain_ctr_pkg::NUM_CTR*chain_ctr_pkg::EV_W-1:0] event_in,
   input wire logic [chain_ctr_pkg::ADDR_W-1:0] addr,
   input wire logic [chain_ctr_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [chain_ctr_pkg::DATA_W-1:0] rdata,
   output logic perf_monitor_irq,
   output logic [chain_ctr_pkg::NUM_CTR-1:0] running
);
   localparam int N = chain_ctr_pkg::NUM_CTR;
   localparam int DW = chain_ctr_pkg::DATA_W;
   localparam int CW = chain_ctr_pkg::CNT_W;

   logic rst_n;

   // Decoded bus access
   logic [1:0] region;
   logic aligned;
   logic [4:0] ctrl_idx;
   logic [4:0] cnt_idx;
   logic cnt_hi;
   logic ctrl_hit;
   logic cnt_hit;

   // Per-counter state
   logic [DW-1:0] ctrl_q [N];
   logic [N-1:0] sticky_q;
   logic [N-1:0] chain_started_q;
   logic [N-1:0] ext_started_q;
   logic [CW-1:0] count [N];
   logic [N-1:0] wrap;
   logic [N-1:0] run;
   logic [N-1:0] sticky_clr;
   logic [N-1:0] sticky_live;
   logic [N-1:0] ctrl_wr;
   logic [N-1:0] load_lo;
   logic [N-1:0] load_hi;

   rst_sync u_rst_sync (
      .mclk(mclk),
      .rstn(rstn),
      .rst_n_sync(rst_n)
   );

   function automatic logic [DW-1:0] ctrl_mask(input int i);
      logic [DW-1:0] m;
      m = chain_ctr_pkg::CTRL_WMASK;
      // Bit 11 exists only on extended-chaining targets
      if (!chain_ctr_pkg::ext_ok(i)) begin
         m[chain_ctr_pkg::EXT_CHAIN_BIT] = 1'b0;
      end
      return m;
   endfunction : ctrl_mask

   assign region = addr[9:8];
   assign aligned = (addr[1:0] == 2'h0);
   assign ctrl_idx = addr[6:2];
   assign cnt_idx = addr[7:3];
   assign cnt_hi = addr[2];
   assign ctrl_hit = aligned && (region == chain_ctr_pkg::REGION_CTRL) && !addr[7]
      && (ctrl_idx < 5'(N));
   assign cnt_hit = aligned && (region == chain_ctr_pkg::REGION_CNT) && (cnt_idx < 5'(N));

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ctr
         localparam int NSRC = chain_ctr_pkg::norm_src(g);
         localparam int ESRC = chain_ctr_pkg::ext_src(g);
         localparam bit EXT = chain_ctr_pkg::ext_ok(g);

         logic enable;
         logic cascade;
         logic ext_chain;
         logic chain_trig;
         logic ext_trig;
         logic chain_hold;
         logic ext_hold;

         assign ctrl_wr[g] = wr && ctrl_hit && (ctrl_idx == 5'(g));
         assign load_lo[g] = wr && cnt_hit && (cnt_idx == 5'(g)) && !cnt_hi;
         assign load_hi[g] = wr && cnt_hit && (cnt_idx == 5'(g)) && cnt_hi;

         assign enable = ctrl_q[g][chain_ctr_pkg::ENABLE_BIT];
         assign cascade = ctrl_q[g][chain_ctr_pkg::CASCADE_BIT];
         assign ext_chain = EXT && ctrl_q[g][chain_ctr_pkg::EXT_CHAIN_BIT];

         // Software clear of the flag, unless a wrap lands in the same cycle
         assign sticky_clr[g] = ctrl_wr[g] && !wdata[chain_ctr_pkg::STICKY_BIT] && !wrap[g];
         assign sticky_live[g] = sticky_q[g] && !sticky_clr[g];

         // Counters 16 and 17 are never normal sources: no target names them
         assign chain_trig = cascade && !enable && wrap[NSRC];
         assign ext_trig = ext_chain && wrap[ESRC];
         assign chain_hold = cascade && sticky_live[NSRC];
         assign ext_hold = ext_chain && sticky_live[ESRC];

         assign run[g] = enable
            || (chain_started_q[g] && chain_hold)
            || (ext_started_q[g] && ext_hold);

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               ctrl_q[g] <= chain_ctr_pkg::CTRL_RESET;
            end else if (ctrl_wr[g]) begin
               ctrl_q[g] <= wdata & ctrl_mask(g);
            end
         end

         // Sticky flag: a wrap wins over a clear in the same cycle
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               sticky_q[g] <= 1'b0;
            end else if (wrap[g]) begin
               sticky_q[g] <= 1'b1;
            end else if (sticky_clr[g]) begin
               sticky_q[g] <= 1'b0;
            end
         end

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               chain_started_q[g] <= 1'b0;
            end else if (chain_trig) begin
               chain_started_q[g] <= 1'b1;
            end else if (!chain_hold) begin
               chain_started_q[g] <= 1'b0;
            end
         end

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               ext_started_q[g] <= 1'b0;
            end else if (ext_trig) begin
               ext_started_q[g] <= 1'b1;
            end else if (!ext_hold) begin
               ext_started_q[g] <= 1'b0;
            end
         end

         event_counter u_ctr (
            .mclk(mclk),
            .rst_n(rst_n),
            .run(run[g]),
            .inc(event_in[g*chain_ctr_pkg::EV_W +: chain_ctr_pkg::EV_W]),
            .force_wrap(ctrl_q[g][chain_ctr_pkg::FORCE_WRAP_BIT]),
            .load_lo(load_lo[g]),
            .load_hi(load_hi[g]),
            .wdata(wdata),
            .count(count[g]),
            .wrap(wrap[g])
         );
      end
   endgenerate

   // Interrupt request high for one cycle after each cycle with any enabled overflow
   logic [N-1:0] irq_hit;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         irq_hit[i] = wrap[i] && ctrl_q[i][chain_ctr_pkg::IRQ_EN_BIT];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         perf_monitor_irq <= 1'b0;
      end else begin
         perf_monitor_irq <= |irq_hit;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         running <= '0;
      end else begin
         running <= run;
      end
   end

   // Read path: one-cycle latency, no side effects on counters
   logic [DW-1:0] rdata_d;
   logic [CW-1:0] rd_cnt;

   always_comb begin
      rdata_d = chain_ctr_pkg::RDATA_UNMAPPED;
      rd_cnt = count[0];
      if (cnt_hit) begin
         rd_cnt = count[cnt_idx];
      end
      if (ctrl_hit) begin
         rdata_d = ctrl_q[ctrl_idx];
         rdata_d[chain_ctr_pkg::STICKY_BIT] = sticky_q[ctrl_idx];
      end else if (cnt_hit && !cnt_hi) begin
         rdata_d = rd_cnt[DW-1:0];
      end else if (cnt_hit) begin
         rdata_d = {{(2*DW-CW){1'b0}}, rd_cnt[CW-1:DW]};
      end else if (addr == chain_ctr_pkg::RUN_STAT_OFS) begin
         rdata_d = {{(DW-N){1'b0}}, run};
      end else if (addr == chain_ctr_pkg::STICKY_STAT_OFS) begin
         rdata_d = {{(DW-N){1'b0}}, sticky_q};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= chain_ctr_pkg::RDATA_UNMAPPED;
      end else if (rd) begin
         rdata <= rdata_d;
      end else begin
         rdata <= chain_ctr_pkg::RDATA_UNMAPPED;
      end
   end
endmodule : chained_event_counters
`default_nettype wire

// ---- design/chain_ctr_pkg.sv ----
// Purpose: Shared constants and chaining topology for the chained event counters
// Assumes: 18 counters, 32-bit register port, byte addresses
// Notes: Counter width fixed here; wider counters read as two words
`default_nettype none
package chain_ctr_pkg;
   localparam int NUM_CTR = 18;
   localparam int CNT_W = 40;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 10;
   localparam int EV_W = 4;
   localparam int BLK_SIZE = 4;
   localparam int QUEUE_BLK_BASE = 12;

   // Address regions, selected by addr[9:8]
   localparam logic [1:0] REGION_CTRL = 2'h0;
   localparam logic [1:0] REGION_CNT = 2'h1;
   localparam logic [1:0] REGION_STAT = 2'h2;
   localparam logic [ADDR_W-1:0] CTRL_BASE = 10'h000;
   localparam logic [ADDR_W-1:0] CNT_BASE = 10'h100;
   localparam logic [ADDR_W-1:0] RUN_STAT_OFS = 10'h200;
   localparam logic [ADDR_W-1:0] STICKY_STAT_OFS = 10'h204;

   // Control register field positions
   localparam int EXT_CHAIN_BIT = 11;
   localparam int ENABLE_BIT = 12;
   localparam int SEL_LSB = 13;
   localparam int SEL_MSB = 15;
   localparam int FORCE_WRAP_BIT = 25;
   localparam int IRQ_EN_BIT = 26;
   localparam int CASCADE_BIT = 30;
   localparam int STICKY_BIT = 31;

   localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h4600F800;
   localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
   localparam logic [CNT_W-1:0] CNT_RESET = 40'h0000000000;
   localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 32'h00000000;

   // Normal chaining source: first with third, second with fourth of a block
   function automatic int norm_src(input int i);
      if (i < QUEUE_BLK_BASE) begin
         return i ^ 2;
      end
      case (i)
         12: return 14;
         13: return 15;
         14: return 12;
         15: return 13;
         16: return 14;
         17: return 15;
         default: return i;
      endcase
   endfunction : norm_src

   // Extended chaining source for the fourth block
   function automatic int ext_src(input int i);
      case (i)
         12: return 16;
         15: return 17;
         16: return 17;
         17: return 16;
         default: return i;
      endcase
   endfunction : ext_src

   function automatic bit ext_ok(input int i);
      return (i == 12) || (i == 15) || (i == 16) || (i == 17);
   endfunction : ext_ok
endpackage : chain_ctr_pkg
`default_nettype wire

// ---- design/rst_sync.sv ----
// Purpose: Release an asynchronous active-low reset through two flip-flops
// Assumes: Reset asserts asynchronously, releases on mclk
// Notes: Output is the reset copy for all other logic
`default_nettype none
module rst_sync (
   input wire logic mclk,
   input wire logic rstn,
   output logic rst_n_sync
);
   logic stage_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stage_q <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         stage_q <= 1'b1;
         rst_n_sync <= stage_q;
      end
   end
endmodule : rst_sync
`default_nettype wire

// ---- design/event_counter.sv ----
// Purpose: One wrapping event counter with preload and wrap detection
// Assumes: Increment value comes from logic on mclk
// Notes: A load wins over counting in the same cycle
`default_nettype none
module event_counter (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [chain_ctr_pkg::EV_W-1:0] inc,
   input wire logic force_wrap,
   input wire logic load_lo,
   input wire logic load_hi,
   input wire logic [chain_ctr_pkg::DATA_W-1:0] wdata,
   output logic [chain_ctr_pkg::CNT_W-1:0] count,
   output logic wrap
);
   localparam int HI_W = chain_ctr_pkg::CNT_W - chain_ctr_pkg::DATA_W;
   logic [chain_ctr_pkg::CNT_W:0] sum;
   logic counting;

   assign counting = run && (inc != '0);
   assign sum = {1'b0, count} + {{(chain_ctr_pkg::CNT_W + 1 - chain_ctr_pkg::EV_W){1'b0}}, inc};
   // Force mode turns every increment into a wrap event
   assign wrap = counting && (sum[chain_ctr_pkg::CNT_W] || force_wrap);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= chain_ctr_pkg::CNT_RESET;
      end else if (load_lo) begin
         count <= {count[chain_ctr_pkg::CNT_W-1:chain_ctr_pkg::DATA_W], wdata};
      end else if (load_hi) begin
         count <= {wdata[HI_W-1:0], count[chain_ctr_pkg::DATA_W-1:0]};
      end else if (counting) begin
         count <= sum[chain_ctr_pkg::CNT_W-1:0];
      end
   end
endmodule : event_counter
`default_nettype wire

// ---- dv/ctr_bank_properties.sv ----
// Purpose: Port-level properties of the chained event counter bank
// Assumes: One mclk domain, rstn active low
// Notes: Bound to the top module by the bind after the module
`default_nettype none
module ctr_bank_properties (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [chain_ctr_pkg::NUM_CTR*chain_ctr_pkg::EV_W-1:0] event_in,
   input wire logic [chain_ctr_pkg::ADDR_W-1:0] addr,
   input wire logic [chain_ctr_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [chain_ctr_pkg::DATA_W-1:0] rdata,
   input wire logic perf_monitor_irq,
   input wire logic [chain_ctr_pkg::NUM_CTR-1:0] running
);
   logic irq_armed_q;
   logic arm_wr;
   // An irq pulse is impossible before some control write set its enable
   assign arm_wr = wr && addr[9:8] == chain_ctr_pkg::REGION_CTRL && wdata[26];
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_armed_q <= 1'b0;
      end else if (arm_wr) begin
         irq_armed_q <= 1'b1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_en0_wr;
      wr && addr == chain_ctr_pkg::CTRL_BASE && wdata[chain_ctr_pkg::ENABLE_BIT];
   endsequence
   sequence s_stop0_wr;
      wr && addr == 10'h000 && !wdata[12] && !wdata[30];
   endsequence
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside its cycle");
   AST_RD_UNMAPPED: assert property (rd && addr[9:8] == 2'h3 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RUN_STAT: assert property (rd && addr == 10'h200 |=> rdata == {14'h0, running})
      else $error("run status read differs from running");
   AST_ENABLE_START: assert property (s_en0_wr |-> ##2 running[0])
      else $error("enable write did not start counter");
   AST_DISABLE_STOP: assert property (s_stop0_wr |-> ##2 !running[0])
      else $error("disable write did not stop counter");
   AST_STOP_CAUSE: assert property ($fell(running[0]) |-> $past(wr, 2))
      else $error("counter stopped without a write");
   AST_IRQ_CAUSE: assert property (perf_monitor_irq |-> irq_armed_q)
      else $error("irq without any irq enable");
   AST_RSVD_BIT11: assert property (rd && addr inside {10'h034, 10'h038} |=> !rdata[11])
      else $error("reserved bit 11 reads one");
   AST_CTRL_MASK: assert property (rd && addr[9:8] == 2'h0 |=>
      (rdata & ~(chain_ctr_pkg::CTRL_WMASK | 32'h80000000)) == 32'h0)
      else $error("control read shows unused bits");
endmodule : ctr_bank_properties
bind chained_event_counters ctr_bank_properties u_props (.mclk(mclk), .rstn(rstn),
   .event_in(event_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .perf_monitor_irq(perf_monitor_irq), .running(running));
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the chained event counter bank
// Assumes: Bus master drives just after rising edges of a 100 MHz mclk
// Notes: Register rows first, then counting and chaining cases
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [9:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } row_s;
   logic mclk;
   logic rstn;
   logic [71:0] event_in;
   logic [9:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic perf_monitor_irq;
   logic [17:0] running;
   int fails;
   int total_checks;
   int irq_cnt;
   row_s rows [10];
   chained_event_counters dut (.mclk(mclk), .rstn(rstn), .event_in(event_in), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .perf_monitor_irq(perf_monitor_irq),
      .running(running));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (perf_monitor_irq === 1'b1) irq_cnt++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      check(rdata, e);
   endtask : rd_chk
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   // Whole run needs about 135 cycles
   initial begin
      #50000;
      fails++;
      end_sim();
   end
   initial begin
      rstn = 1'b0;
      event_in = 72'h0;
      addr = 10'h000;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      rows = '{
         '{10'h004, 32'hFFFFEFFF, 32'h4600E000},
         '{10'h030, 32'h00000800, 32'h00000800},
         '{10'h034, 32'h00000800, 32'h00000000},
         '{10'h038, 32'h00000800, 32'h00000000},
         '{10'h03C, 32'h00000800, 32'h00000800},
         '{10'h040, 32'h00000800, 32'h00000800},
         '{10'h044, 32'h00000800, 32'h00000800},
         '{10'h108, 32'h12345678, 32'h12345678},
         '{10'h10C, 32'hFFFFFFFF, 32'h000000FF},
         '{10'h300, 32'hAAAAAAAA, 32'h00000000}};
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      check({14'h0, running}, 32'h0);
      rd_chk(10'h000, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      $display("test registers done");
      // Counter 0 at minus two, chained into counter 2
      event_in[8 +: 4] <= 4'h1;
      wr_reg(10'h100, 32'hFFFFFFFE);
      wr_reg(10'h104, 32'h000000FF);
      wr_reg(10'h008, 32'h40000000);
      wr_reg(10'h000, 32'h04001000);
      @(posedge mclk);
      event_in[3:0] <= 4'h5;
      repeat (3) @(posedge mclk);
      event_in[3:0] <= 4'h0;
      rd_chk(10'h100, 32'h0000000D);
      rd_chk(10'h104, 32'h0);
      rd_chk(10'h000, 32'h84001000);
      rd_chk(10'h200, 32'h00000005);
      check(irq_cnt, 32'h1);
      wr_reg(10'h000, 32'h84000000);
      // Events keep arriving, so a missed stop would move the count
      event_in[3:0] <= 4'h1;
      rd_chk(10'h100, 32'h0000000D);
      rd_chk(10'h000, 32'h84000000);
      rd_chk(10'h200, 32'h00000004);
      wr_reg(10'h000, 32'h04000000);
      rd_chk(10'h200, 32'h0);
      $display("test chain done");
      // Counter 16 wraps; 14 armed normally must stay idle
      event_in[64 +: 4] <= 4'h1;
      wr_reg(10'h038, 32'h40000000);
      wr_reg(10'h180, 32'hFFFFFFFF);
      wr_reg(10'h184, 32'h000000FF);
      wr_reg(10'h040, 32'h00001000);
      repeat (4) @(posedge mclk);
      rd_chk(10'h200, 32'h00031000);
      rd_chk(10'h040, 32'h80001000);
      event_in[68 +: 4] <= 4'h1;
      wr_reg(10'h18C, 32'h000000FF);
      wr_reg(10'h188, 32'hFFFFFFFF);
      repeat (4) @(posedge mclk);
      rd_chk(10'h200, 32'h00039000);
      $display("test extended chain done");
      // Force wrap on counter 3: one increment from zero is an overflow
      wr_reg(10'h00C, 32'h06001000);
      event_in[12 +: 4] <= 4'h1;
      @(posedge mclk);
      event_in[12 +: 4] <= 4'h0;
      rd_chk(10'h118, 32'h00000001);
      rd_chk(10'h00C, 32'h86001000);
      rd_chk(10'h204, 32'h00030008);
      rd_chk(10'h200, 32'h0003900A);
      check(irq_cnt, 32'h2);
      $display("test force wrap done");
      // Reset in mid-run clears controls, counts and flags
      @(posedge mclk);
      rstn <= 1'b0;
      @(posedge mclk);
      #1;
      check({14'h0, running}, 32'h0);
      @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      rd_chk(10'h040, 32'h0);
      rd_chk(10'h184, 32'h0);
      rd_chk(10'h204, 32'h0);
      rd_chk(10'h200, 32'h0);
      $display("test reset again done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
